/* File: design/scp_pkg.sv */
package scp_pkg;
  // Summary of operation
  // - Active serial offers four clock rate settings; all four clamp to the same AS_MIN_HALF half period, so one clock rate.
  // - Chained devices never use the fastest rate.
  // - Quad variant moves four bits per clock.
  // - Active serial launches and captures on falling edge.
  // - Init clock from oscillator or user clock.
  // - Oscillator init ends 175 to 437 us.
  // - User clock used after gap, then 8576 cycles.
  // - User mode: request, status, done all high.
  // - Request low pulls done and status low quickly.
  // - Host holds request low at least 2 us.
  // - Status held low through power-on delay.
  // - Status low 268 to 1506 us after request.
  // - Status held low externally delays data acceptance.
  // - Host delays first passive clock rising edge.
  // - Done low from power-up until loading completes.
  // - Done rises only after the whole bitstream.
  // - Host gives two falling edges after done.
  // - Host keeps clock driven after configuration.
  // - Serial input becomes user pin after configuration.
  // - Init-done output driven low from done until initialization finishes.
  // - Passive mode samples on rising edge, max 125 MHz.
  localparam int CLK_NS = 25;
  localparam int CLK_KHZ = 40000;
  localparam int REQ_REACT_MAX_NS = 600;
  localparam int REQ_REACT_MAX_CYC = REQ_REACT_MAX_NS / CLK_NS;
  localparam int REQ_LOW_MIN_US = 2;
  localparam int REQ_LOW_MIN_CYC = (REQ_LOW_MIN_US * 1000 + CLK_NS - 1) / CLK_NS;
  localparam int STATUS_LOW_MIN_US = 268;
  localparam int STATUS_LOW_MIN_CYC = (STATUS_LOW_MIN_US * 1000 + CLK_NS - 1) / CLK_NS;
  localparam int STATUS_LOW_MAX_US = 1506;
  localparam int STATUS_LOW_MAX_CYC = STATUS_LOW_MAX_US * 1000 / CLK_NS;
  localparam int REQ_TO_CLK_MIN_US = 1506;
  localparam int REQ_TO_CLK_MIN_CYC = (REQ_TO_CLK_MIN_US * 1000 + CLK_NS - 1) / CLK_NS;
  localparam int ST_TO_CLK_MIN_US = 2;
  localparam int ST_TO_CLK_MIN_CYC = (ST_TO_CLK_MIN_US * 1000 + CLK_NS - 1) / CLK_NS;
  localparam int OSC_INIT_MIN_US = 175;
  localparam int OSC_INIT_MAX_US = 437;
  localparam int OSC_INIT_CYC = (OSC_INIT_MIN_US * 1000 + CLK_NS - 1) / CLK_NS;
  localparam int PS_FMAX_KHZ = 125000;
  localparam int UCLK_GAP_PERIODS = 4;
  localparam int UCLK_GAP_NS = UCLK_GAP_PERIODS * 1000000 / PS_FMAX_KHZ;
  localparam int UCLK_GAP_CYC = (UCLK_GAP_NS + CLK_NS - 1) / CLK_NS;
  localparam int USER_INIT_CYCLES = 8576;
  localparam int AS_FMAX_KHZ [4] = '{12500, 25000, 50000, 100000};
  localparam int AS_TOP_RATE = 3;
  localparam int AS_CMD_BITS = 8;
  localparam int TAIL_FALLS = 2;
  localparam int HOST_HALF_CYC = 4;
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_STAT = 4'h4;
  localparam logic [3:0] REG_DATA = 4'h8;
  localparam int CTRL_START = 0;
  localparam int CTRL_AS = 1;
  localparam int CTRL_QUAD = 2;
  localparam int CTRL_MON = 3;
  localparam int CTRL_UCLK = 4;
  localparam int CTRL_HOLD = 5;
  localparam logic [5:0] CTRL_RST = 6'h00;
  localparam logic [31:0] DATA_RST = 32'h0000_0000;
  localparam logic [1:0] RESP_OK = 2'h0;
  localparam logic [1:0] RESP_ERR = 2'h2;
  typedef enum {ST_POR, ST_REQ, ST_HOLD, ST_WAIT, ST_LOAD, ST_TAIL, ST_UWAIT, ST_INIT,
                ST_USER} scp_dev_e;
  typedef enum {H_IDLE, H_REQ, H_WAIT, H_SEND, H_TAIL} scp_host_e;
endpackage

/* File: design/scp_if.sv */
`timescale 1ns/10ps
interface scp_if;
  logic       config_request_n;
  logic       status_dev_oe;
  logic       status_host_oe;
  logic       config_status_n;
  logic       config_done;
  logic       clk_dev_o;
  logic       clk_dev_oe;
  logic       clk_host_o;
  logic       clk_host_oe;
  logic       config_clock;
  logic       serial_data_in;
  logic       as_serial_out;
  logic [3:0] as_quad_data_bus;
  logic       user_init_clock;
  logic       init_done_o;
  logic       init_done_oe;
  logic       init_done;

  // Open-drain status with pull-up, shared clock with pull-down, init-done with pull-up.
  assign config_status_n = ~(status_dev_oe | status_host_oe);
  assign config_clock = clk_dev_oe ? clk_dev_o : (clk_host_oe ? clk_host_o : 1'b0);
  assign init_done = init_done_oe ? init_done_o : 1'b1;

  modport device (input config_request_n, config_status_n, config_clock, serial_data_in,
                  as_quad_data_bus, user_init_clock,
                  output status_dev_oe, config_done, clk_dev_o, clk_dev_oe, as_serial_out,
                  init_done_o, init_done_oe);
  modport host (output config_request_n, status_host_oe, clk_host_o, clk_host_oe,
                serial_data_in, as_quad_data_bus, user_init_clock,
                input config_status_n, config_done, config_clock, as_serial_out, init_done);
endinterface

/* File: design/scp_sync.sv */
`timescale 1ns/10ps
module scp_sync #(
  parameter int W = 1
) (
  input  wire logic         clk_i,
  input  wire logic         sys_rst_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o,
  output logic      [W-1:0] rise_o,
  output logic      [W-1:0] fall_o
);
  logic [W-1:0] meta;
  logic [W-1:0] q;
  logic [W-1:0] q_d;

  always_ff @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      meta <= '0;
      q    <= '0;
      q_d  <= '0;
    end
    else
    begin
      meta <= d_i;
      q    <= meta;
      q_d  <= q;
    end
  end

  assign q_o    = q;
  assign rise_o = q & ~q_d;
  assign fall_o = ~q & q_d;
endmodule // scp_sync

/* File: design/scp_device.sv */
`timescale 1ns/10ps
module scp_device #(
  parameter int         BITS        = 256,
  parameter int         STATUS_CYC  = scp_pkg::STATUS_LOW_MIN_CYC,
  parameter int         OSC_CYC     = scp_pkg::OSC_INIT_CYC,
  parameter int         AS_MIN_HALF = 4,
  parameter logic [7:0] READ_CMD    = 8'h03
) (
  input  wire logic        clk_i,
  input  wire logic        sys_rst_i,
  input  wire logic        as_mode_i,
  input  wire logic        quad_i,
  input  wire logic [1:0]  rate_sel_i,
  input  wire logic        multi_dev_i,
  input  wire logic        user_clk_sel_i,
  input  wire logic        init_done_en_i,
  input  wire logic        user_io_en_i,
  scp_if.device            bus,
  output logic      [31:0] load_word_o,
  output logic             load_valid_o,
  output logic             user_mode_o,
  output logic             user_io_o
);
  scp_pkg::scp_dev_e state;
  logic [8:0]  s_q;
  logic [8:0]  s_r;
  logic [8:0]  s_f;
  logic        req_n;
  logic        st;
  logic        ck_rise;
  logic        ck_fall;
  logic        uclk_rise;
  logic [3:0]  qd;
  logic [19:0] cnt;
  logic [31:0] bcnt;
  logic [31:0] next_bcnt;
  logic [31:0] word;
  logic [31:0] next_word;
  logic [3:0]  cmd_cnt;
  logic        as_clk;
  logic [7:0]  hcnt;
  logic [7:0]  half;
  logic [1:0]  rate;
  logic        as_fall;
  logic        take;
  logic        done_q;
  logic        stat_oe;
  logic        as_out;

  scp_sync #(.W(9)) u_sync (
    .clk_i     (clk_i),
    .sys_rst_i (sys_rst_i),
    .d_i       ({bus.as_quad_data_bus, bus.serial_data_in, bus.user_init_clock,
                 bus.config_clock, bus.config_status_n, bus.config_request_n}),
    .q_o       (s_q),
    .rise_o    (s_r),
    .fall_o    (s_f)
  );

  assign req_n     = s_q[0];
  assign st        = s_q[1];
  assign ck_rise   = s_r[2];
  assign ck_fall   = s_f[2];
  assign uclk_rise = s_r[3];
  assign qd        = s_q[8:5];

  // Half period of the generated clock; the divider cannot go below AS_MIN_HALF cycles.
  function automatic logic [7:0] half_cyc(input logic [1:0] sel);
    int h;
    h = (scp_pkg::CLK_KHZ + 2 * scp_pkg::AS_FMAX_KHZ[sel] - 1) / (2 * scp_pkg::AS_FMAX_KHZ[sel]);
    if (h < AS_MIN_HALF)
    begin
      h = AS_MIN_HALF;
    end
    return 8'(h);
  endfunction

  // The fastest setting is folded down one step when devices are chained.
  assign rate = (multi_dev_i && rate_sel_i == 2'(scp_pkg::AS_TOP_RATE)) ?
                2'(scp_pkg::AS_TOP_RATE - 1) : rate_sel_i;
  assign half = half_cyc(rate);

  always_ff @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      state <= scp_pkg::ST_POR;
      cnt   <= '0;
    end
    else if (!req_n && state != scp_pkg::ST_POR)
    begin
      state <= scp_pkg::ST_REQ;
      cnt   <= '0;
    end
    else
    begin
      unique case (state)
        scp_pkg::ST_POR, scp_pkg::ST_HOLD:
        begin
          if (cnt == 20'(STATUS_CYC - 1))
          begin
            state <= scp_pkg::ST_WAIT;
            cnt   <= '0;
          end
          else
          begin
            cnt <= cnt + 20'h0_0001;
          end
        end
        scp_pkg::ST_REQ:
        begin
          if (req_n)
          begin
            state <= scp_pkg::ST_HOLD;
          end
        end
        scp_pkg::ST_WAIT:
        begin
          if (st)
          begin
            state <= scp_pkg::ST_LOAD;
          end
        end
        scp_pkg::ST_LOAD:
        begin
          if (bcnt == 32'(BITS))
          begin
            state <= scp_pkg::ST_TAIL;
          end
        end
        scp_pkg::ST_TAIL:
        begin
          if (as_mode_i || (ck_fall && cnt == 20'(scp_pkg::TAIL_FALLS - 1)))
          begin
            state <= user_clk_sel_i ? scp_pkg::ST_UWAIT : scp_pkg::ST_INIT;
            cnt   <= '0;
          end
          else if (ck_fall)
          begin
            cnt <= cnt + 20'h0_0001;
          end
        end
        scp_pkg::ST_UWAIT:
        begin
          if (cnt == 20'(scp_pkg::UCLK_GAP_CYC - 1))
          begin
            state <= scp_pkg::ST_INIT;
            cnt   <= '0;
          end
          else
          begin
            cnt <= cnt + 20'h0_0001;
          end
        end
        scp_pkg::ST_INIT:
        begin
          if (user_clk_sel_i)
          begin
            if (uclk_rise && cnt == 20'(scp_pkg::USER_INIT_CYCLES - 1))
            begin
              state <= scp_pkg::ST_USER;
            end
            else if (uclk_rise)
            begin
              cnt <= cnt + 20'h0_0001;
            end
          end
          else if (cnt == 20'(OSC_CYC - 1))
          begin
            state <= scp_pkg::ST_USER;
          end
          else
          begin
            cnt <= cnt + 20'h0_0001;
          end
        end
        scp_pkg::ST_USER:
        begin
          state <= scp_pkg::ST_USER;
        end
      endcase
    end
  end

  // Generated clock, low outside loading; its falling edge drives launch and capture.
  always_ff @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      as_clk <= 1'b0;
      hcnt   <= '0;
    end
    else if (!as_mode_i || state != scp_pkg::ST_LOAD)
    begin
      as_clk <= 1'b0;
      hcnt   <= '0;
    end
    else if (hcnt == half - 8'h01)
    begin
      as_clk <= ~as_clk;
      hcnt   <= '0;
    end
    else
    begin
      hcnt <= hcnt + 8'h01;
    end
  end

  assign as_fall = as_mode_i && state == scp_pkg::ST_LOAD && as_clk && hcnt == half - 8'h01;
  assign take    = as_mode_i ? (as_fall && cmd_cnt == 4'(scp_pkg::AS_CMD_BITS))
                             : ck_rise;
  assign next_bcnt = bcnt + ((as_mode_i && quad_i) ? 32'h0000_0004 : 32'h0000_0001);
  assign next_word = (as_mode_i && quad_i) ? {word[27:0], qd}
                   : {word[30:0], as_mode_i ? qd[1] : s_q[4]};

  always_ff @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      word         <= '0;
      bcnt         <= '0;
      cmd_cnt      <= '0;
      as_out       <= 1'b0;
      load_word_o  <= '0;
      load_valid_o <= 1'b0;
    end
    else
    begin
      load_valid_o <= 1'b0;
      if (state != scp_pkg::ST_LOAD)
      begin
        bcnt    <= '0;
        cmd_cnt <= '0;
        as_out  <= 1'b0;
      end
      else
      begin
        if (as_fall && cmd_cnt != 4'(scp_pkg::AS_CMD_BITS))
        begin
          as_out  <= READ_CMD[3'(scp_pkg::AS_CMD_BITS - 1) - cmd_cnt[2:0]];
          cmd_cnt <= cmd_cnt + 4'h1;
        end
        else if (as_fall)
        begin
          as_out <= 1'b0;
        end
        if (take && bcnt != 32'(BITS))
        begin
          word <= next_word;
          bcnt <= next_bcnt;
          if (next_bcnt[4:0] == 5'h00)
          begin
            load_word_o  <= next_word;
            load_valid_o <= 1'b1;
          end
        end
      end
    end
  end

  always_ff @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      done_q      <= 1'b0;
      stat_oe     <= 1'b1;
      user_mode_o <= 1'b0;
      user_io_o   <= 1'b0;
    end
    else
    begin
      done_q      <= state inside {scp_pkg::ST_TAIL, scp_pkg::ST_UWAIT, scp_pkg::ST_INIT,
                                   scp_pkg::ST_USER};
      stat_oe     <= state inside {scp_pkg::ST_POR, scp_pkg::ST_REQ, scp_pkg::ST_HOLD};
      user_mode_o <= state == scp_pkg::ST_USER;
      user_io_o   <= state == scp_pkg::ST_USER && user_io_en_i && s_q[4];
    end
  end

  assign bus.config_done   = done_q;
  assign bus.status_dev_oe = stat_oe;
  assign bus.clk_dev_o     = as_clk;
  assign bus.clk_dev_oe    = as_mode_i;
  assign bus.as_serial_out = as_out;
  assign bus.init_done_o   = user_mode_o;
  assign bus.init_done_oe  = init_done_en_i && done_q;
endmodule // scp_device

/* File: design/scp_host.sv */
`timescale 1ns/10ps
module scp_host #(
  parameter int CF2CK_CYC = scp_pkg::REQ_TO_CLK_MIN_CYC,
  parameter int HALF      = scp_pkg::HOST_HALF_CYC
) (
  input  wire logic        clk_i,
  input  wire logic        sys_rst_i,
  input  wire logic [3:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic      [1:0]  s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [3:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic      [31:0] s_axi_rdata,
  output logic      [1:0]  s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  scp_if.host              bus
);
  scp_pkg::scp_host_e state;
  logic [3:0]  s_q;
  logic [3:0]  s_f;
  logic [5:0]  ctrl;
  logic [31:0] data;
  logic        start;
  logic        aw_have;
  logic        w_have;
  logic [3:0]  awaddr;
  logic [31:0] wdata;
  logic [3:0]  wstrb;
  logic [19:0] cnt;
  logic        hclk;
  logic [7:0]  hcnt;
  logic        hfall;
  logic        run;
  logic        uclk;
  logic [7:0]  ucnt;
  logic [31:0] shift;
  logic [4:0]  bidx;
  logic [4:0]  step;
  logic [3:0]  fcnt;
  logic        sdo;
  logic [3:0]  qbus;

  scp_sync #(.W(4)) u_sync (
    .clk_i     (clk_i),
    .sys_rst_i (sys_rst_i),
    .d_i       ({bus.init_done, bus.config_clock, bus.config_done, bus.config_status_n}),
    .q_o       (s_q),
    .rise_o    (),
    .fall_o    (s_f)
  );

  assign s_axi_awready = !aw_have && !s_axi_bvalid;
  assign s_axi_wready  = !w_have && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      aw_have <= 1'b0;
      w_have  <= 1'b0;
      awaddr  <= '0;
      wdata   <= '0;
      wstrb   <= '0;
      ctrl    <= scp_pkg::CTRL_RST;
      data    <= scp_pkg::DATA_RST;
      start   <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= scp_pkg::RESP_OK;
    end
    else
    begin
      start <= 1'b0;
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_have <= 1'b1;
        awaddr  <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_have <= 1'b1;
        wdata  <= s_axi_wdata;
        wstrb  <= s_axi_wstrb;
      end
      if (aw_have && w_have)
      begin
        aw_have      <= 1'b0;
        w_have       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= scp_pkg::RESP_OK;
        if (awaddr == scp_pkg::REG_CTRL && wstrb[0])
        begin
          ctrl  <= wdata[5:0] & ~6'h01;
          start <= wdata[scp_pkg::CTRL_START];
        end
        else if (awaddr == scp_pkg::REG_DATA)
        begin
          for (int i = 0; i < 4; i++)
          begin
            if (wstrb[i])
            begin
              data[8*i +: 8] <= wdata[8*i +: 8];
            end
          end
        end
        else if (awaddr != scp_pkg::REG_CTRL && awaddr != scp_pkg::REG_STAT)
        begin
          s_axi_bresp <= scp_pkg::RESP_ERR;
        end
      end
      else if (s_axi_bvalid && s_axi_bready)
      begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= '0;
      s_axi_rresp  <= scp_pkg::RESP_OK;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= scp_pkg::RESP_OK;
      unique case (s_axi_araddr)
        scp_pkg::REG_CTRL: s_axi_rdata <= {26'h000_0000, ctrl};
        scp_pkg::REG_STAT: s_axi_rdata <= {28'h000_0000, state != scp_pkg::H_IDLE, s_q[3],
                                           s_q[0], s_q[1]};
        scp_pkg::REG_DATA: s_axi_rdata <= data;
        default:
        begin
          s_axi_rdata <= '0;
          s_axi_rresp <= scp_pkg::RESP_ERR;
        end
      endcase
    end
    else if (s_axi_rvalid && s_axi_rready)
    begin
      s_axi_rvalid <= 1'b0;
    end
  end

  always_ff @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      state <= scp_pkg::H_IDLE;
      cnt   <= '0;
    end
    else
    begin
      unique case (state)
        scp_pkg::H_IDLE:
        begin
          cnt <= '0;
          if (start)
          begin
            state <= scp_pkg::H_REQ;
          end
        end
        scp_pkg::H_REQ:
        begin
          cnt <= cnt + 20'h0_0001;
          if (cnt == 20'(scp_pkg::REQ_LOW_MIN_CYC - 1))
          begin
            state <= scp_pkg::H_WAIT;
            cnt   <= '0;
          end
        end
        scp_pkg::H_WAIT:
        begin
          cnt <= (ctrl[scp_pkg::CTRL_MON] && !s_q[0]) ? '0 : cnt + 20'h0_0001;
          if (ctrl[scp_pkg::CTRL_AS] ||
              (ctrl[scp_pkg::CTRL_MON] && s_q[0] &&
               cnt == 20'(scp_pkg::ST_TO_CLK_MIN_CYC - 1)) ||
              (!ctrl[scp_pkg::CTRL_MON] && cnt == 20'(CF2CK_CYC - 1)))
          begin
            state <= scp_pkg::H_SEND;
          end
        end
        scp_pkg::H_SEND:
        begin
          cnt <= '0;
          if (s_q[1])
          begin
            state <= ctrl[scp_pkg::CTRL_AS] ? scp_pkg::H_IDLE : scp_pkg::H_TAIL;
          end
        end
        scp_pkg::H_TAIL:
        begin
          if (hfall)
          begin
            cnt <= cnt + 20'h0_0001;
            if (cnt == 20'(scp_pkg::TAIL_FALLS - 1))
            begin
              state <= scp_pkg::H_IDLE;
            end
          end
        end
      endcase
    end
  end

  assign run   = !ctrl[scp_pkg::CTRL_AS] && state inside {scp_pkg::H_SEND, scp_pkg::H_TAIL};
  assign hfall = run && hclk && hcnt == 8'(HALF - 1);
  assign step  = ctrl[scp_pkg::CTRL_QUAD] ? 5'h04 : 5'h01;

  // Clock rests low whenever the host is not clocking; the host drives it only while CTRL_AS is clear.
  always_ff @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      hclk <= 1'b0;
      hcnt <= '0;
    end
    else if (!run)
    begin
      hclk <= 1'b0;
      hcnt <= '0;
    end
    else if (hcnt == 8'(HALF - 1))
    begin
      hclk <= ~hclk;
      hcnt <= '0;
    end
    else
    begin
      hcnt <= hcnt + 8'h01;
    end
  end

  always_ff @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      uclk <= 1'b0;
      ucnt <= '0;
    end
    else if (!(ctrl[scp_pkg::CTRL_UCLK] && s_q[1]))
    begin
      uclk <= 1'b0;
      ucnt <= '0;
    end
    else if (ucnt == 8'(HALF - 1))
    begin
      uclk <= ~uclk;
      ucnt <= '0;
    end
    else
    begin
      ucnt <= ucnt + 8'h01;
    end
  end

  always_ff @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      shift <= '0;
      bidx  <= '0;
      fcnt  <= '0;
      sdo   <= 1'b0;
      qbus  <= '0;
    end
    else if (state != scp_pkg::H_SEND)
    begin
      shift <= data;
      bidx  <= '0;
      fcnt  <= '0;
      sdo   <= data[31];
    end
    else if (!ctrl[scp_pkg::CTRL_AS] && hfall)
    begin
      bidx  <= bidx + 5'h01;
      shift <= (bidx == 5'h1f) ? data : {shift[30:0], 1'b0};
      sdo   <= (bidx == 5'h1f) ? data[31] : shift[30];
    end
    else if (ctrl[scp_pkg::CTRL_AS] && s_f[2])
    begin
      if (fcnt != 4'(scp_pkg::AS_CMD_BITS))
      begin
        fcnt <= fcnt + 4'h1;
      end
      if (fcnt >= 4'(scp_pkg::AS_CMD_BITS - 1))
      begin
        qbus  <= ctrl[scp_pkg::CTRL_QUAD] ? shift[31:28] : {2'b00, shift[31], 1'b0};
        bidx  <= bidx + step;
        shift <= (bidx == 5'h00 - step) ? data :
                 (ctrl[scp_pkg::CTRL_QUAD] ? {shift[27:0], 4'h0} : {shift[30:0], 1'b0});
      end
    end
  end

  assign bus.config_request_n = state != scp_pkg::H_REQ;
  assign bus.status_host_oe   = ctrl[scp_pkg::CTRL_HOLD];
  assign bus.clk_host_o       = hclk;
  assign bus.clk_host_oe      = !ctrl[scp_pkg::CTRL_AS];
  assign bus.serial_data_in   = sdo;
  assign bus.as_quad_data_bus = qbus;
  assign bus.user_init_clock  = uclk;
endmodule // scp_host

/* File: tb/scp_props.sv */
`timescale 1ns/10ps
module scp_props (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic config_request_n,
  input wire logic config_status_n,
  input wire logic config_done,
  input wire logic config_clock,
  input wire logic clk_dev_oe,
  input wire logic as_serial_out,
  input wire logic init_done
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  req_react_a: assert property ($fell(config_request_n) |->
    ##[1:24] !(config_done | config_status_n)) else $error("request not answered");
  req_done_a: assert property (!config_request_n[*8] |-> !config_done)
    else $error("done high during request");
  done_fall_a: assert property ($fell(config_done) |-> !config_request_n)
    else $error("done fell without request");
  done_rise_a: assert property ($rose(config_done) |-> config_status_n && config_request_n)
    else $error("done rose while held");
  status_rise_a: assert property ($rose(config_status_n) |-> config_request_n)
    else $error("status released during request");
  as_launch_a: assert property (clk_dev_oe && $changed(as_serial_out) |-> !config_clock)
    else $error("launch not after falling edge");
  as_half_a: assert property (clk_dev_oe && $rose(config_clock) |-> config_clock[*4])
    else $error("active clock high too short");
  user_mode_a: assert property ($rose(init_done) |->
    config_done && config_status_n && config_request_n) else $error("user mode levels wrong");
endmodule // scp_props

/* File: tb/serial_config_port_tb.sv */
`timescale 1ns/10ps
module serial_config_port_tb;
  localparam logic [31:0] W = 32'hA5C3_0F96;
  logic clk_i = 1'b0, sys_rst_i = 1'b1, as_m = 1'b0, quad = 1'b0, multi = 1'b0, usel = 1'b0;
  logic [1:0] rate = 2'h0;
  logic uioe = 1'b1;
  logic [3:0] awaddr = 4'h0, araddr = 4'h0, strb = 4'hF;
  logic [31:0] wdata = 32'h0000_0000;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, lv, um, uio;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata, word_o;
  int n_mismatch = 0, checked = 0, words = 0;
  always #12.5 clk_i = ~clk_i;
  scp_if b();
  scp_device #(.BITS(64), .STATUS_CYC(20), .OSC_CYC(20)) scp_device_inst (.clk_i(clk_i),
    .sys_rst_i(sys_rst_i), .as_mode_i(as_m), .quad_i(quad), .rate_sel_i(rate),
    .multi_dev_i(multi), .user_clk_sel_i(usel), .init_done_en_i(1'b1), .user_io_en_i(uioe),
    .bus(b), .load_word_o(word_o), .load_valid_o(lv), .user_mode_o(um), .user_io_o(uio));
  scp_host #(.CF2CK_CYC(50)) scp_host_inst (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(strb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .bus(b));
  scp_props scp_props_inst (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
    .config_request_n(b.config_request_n), .config_status_n(b.config_status_n),
    .config_done(b.config_done), .config_clock(b.config_clock), .clk_dev_oe(b.clk_dev_oe),
    .as_serial_out(b.as_serial_out), .init_done(b.init_done));
  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e)
    begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] r);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(posedge clk_i);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    bready <= 1'b0;
    chk("bresp", bresp, r);
    // One idle edge keeps bready from being lowered and raised in one time step.
    @(posedge clk_i);
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] e, input logic [1:0] r);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(posedge clk_i);
      if (arready === 1'b1) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rready <= 1'b0;
    chk("rdata", rdata, e);
    chk("rresp", rresp, r);
    @(posedge clk_i);
  endtask
  task automatic wt(input logic w);
    for (int i = 0; i < 80000 && um !== w; i++) @(posedge clk_i);
    chk("user mode", um, w);
  endtask
  task end_of_test;
    $display("checks %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  always @(posedge clk_i)
  begin
    if (lv === 1'b1)
    begin
      words++;
      chk("word", word_o, W);
    end
  end
  initial
  begin
    repeat (90000) @(posedge clk_i);
    n_mismatch++;
    end_of_test;
  end
  initial
  begin
    repeat (16) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    rd(scp_pkg::REG_CTRL, 32'h0000_0000, scp_pkg::RESP_OK);
    rd(scp_pkg::REG_DATA, scp_pkg::DATA_RST, scp_pkg::RESP_OK);
    rd(4'hC, 32'h0000_0000, scp_pkg::RESP_ERR);
    wr(4'hC, W, scp_pkg::RESP_ERR);
    wr(scp_pkg::REG_DATA, W, scp_pkg::RESP_OK);
    strb <= 4'hE;
    wr(scp_pkg::REG_CTRL, 32'h0000_0001, scp_pkg::RESP_OK);
    strb <= 4'hF;
    rd(scp_pkg::REG_CTRL, 32'h0000_0000, scp_pkg::RESP_OK);
    usel <= 1'b1;
    wr(scp_pkg::REG_CTRL, 32'h0000_0019, scp_pkg::RESP_OK);
    rd(scp_pkg::REG_CTRL, 32'h0000_0018, scp_pkg::RESP_OK);
    wt(1'b1);
    // Status bits pass a two-stage synchroniser before they can be read.
    repeat (3) @(posedge clk_i);
    rd(scp_pkg::REG_STAT, 32'h0000_0007, scp_pkg::RESP_OK);
    chk("user io", uio, b.serial_data_in);
    uioe <= 1'b0;
    repeat (2) @(posedge clk_i);
    chk("user io off", uio, 32'h0000_0000);
    as_m <= 1'b1;
    quad <= 1'b1;
    rate <= 2'h3;
    multi <= 1'b1;
    usel <= 1'b0;
    wr(scp_pkg::REG_CTRL, 32'h0000_0007, scp_pkg::RESP_OK);
    wt(1'b0);
    wt(1'b1);
    chk("words", words, 4);
    quad <= 1'b0;
    rate <= 2'h0;
    multi <= 1'b0;
    wr(scp_pkg::REG_CTRL, 32'h0000_0003, scp_pkg::RESP_OK);
    wt(1'b0);
    wt(1'b1);
    chk("words single", words, 6);
    end_of_test;
  end
endmodule // serial_config_port_tb
